// ### src/window_watchdog_control.sv
// Window watchdog: control and service registers, mode handling and reset request.
// Assumes a byte register port with one-cycle strobes and read data one cycle later.
//
// Functional notes
// - Counter stays stopped while the rate select field is zero.
// - Wait-halt clear keeps counting in wait; set stops and clears the counter.
// - Stop-run set keeps counting in stop; clear holds the count unchanged.
// - Debug-stop writable freely in special modes; otherwise only a one is accepted.
// - Window and rate take one write outside special modes, any number inside.
// - Writing zero rate or zero window changes nothing yet uses the single write.
// - Wait-halt and stop-run take one write outside special modes.
// - Period restarts on accepted non-zero rate write unmasked, or debug-stop rising.
// - Write mask is write-only; when set, protected fields and allowance are untouched.
// - In window mode a service write in the first 75% requests reset.
// - Second key after first restarts timing; software waits for the next window.
// - Debug-stop set halts watchdog and tick counters during active debug.
// - Non-zero rate enables counting; expiry requests a system reset.
// - Enabled, debugging, debug-stop clear, special mode: longest period, no window.
// - Control reads anytime, bit 5 reads zero, fields at bits 7,6,4,3,2..0.
// - Rate codes 1..7 give 2^6,8,10,12,14,15,16 cycles; code 0 disables.
// - Keys are first then second value; any other value requests immediate reset.
// - Service register reads zero and accepts writes at any time.
// - With rate zero, service writes do nothing and never request reset.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module window_watchdog_control (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic special_mode,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic debug_active_mode,
    output logic [7:0] rdata,
    output logic reset_request,
    output logic tick_halt,
    output logic counter_running
);

    watchdog_pkg::ctl_s ctl_q;
    watchdog_pkg::ctl_s wr_ctl;
    logic fields_locked_q;
    logic [7:0] rdata_q;
    logic reset_request_q;
    logic tick_halt_q;
    logic running_q;
    logic wait_mode_q;
    watchdog_pkg::svc_state_e svc_q;

    logic ctl_wr;
    logic key_wr;
    logic fields_open;
    logic field_write;
    logic rate_restart;
    logic debug_restart;
    logic svc_restart;
    logic svc_fault;
    logic enabled;
    logic debug_override;
    logic [2:0] eff_rate;
    logic eff_window;
    logic debug_halt;
    logic wait_halt_now;
    logic wait_entry;
    logic stop_hold;
    logic run;
    logic restart;
    logic expired;
    logic window_open;

    assign ctl_wr = wr_en && (addr == watchdog_pkg::CTL_OFFSET);
    assign key_wr = wr_en && (addr == watchdog_pkg::KEY_OFFSET);

    assign wr_ctl.window = wdata[watchdog_pkg::WINDOW_POS];
    assign wr_ctl.debug_stop = wdata[watchdog_pkg::DEBUG_STOP_POS];
    assign wr_ctl.wait_halt = wdata[watchdog_pkg::WAIT_HALT_POS];
    assign wr_ctl.stop_run = wdata[watchdog_pkg::STOP_RUN_POS];
    assign wr_ctl.rate = wdata[watchdog_pkg::RATE_MSB:0];

    // Protected fields may be written when not yet locked or in special modes.
    assign fields_open = special_mode || !fields_locked_q;
    assign field_write = ctl_wr && !wdata[watchdog_pkg::WRITE_MASK_POS] && fields_open;

    // Only a non-zero value written under an open, unmasked write restarts the period.
    assign rate_restart = field_write && (wr_ctl.rate != watchdog_pkg::RATE_OFF);
    assign debug_restart = ctl_wr && !ctl_q.debug_stop && wr_ctl.debug_stop;

    // Field register: window and rate ignore zero writes outside special modes.
    // Debug-stop is outside the mask and outside the write-once lock; it shares this
    // process so that the whole control word has a single driver.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctl_q.window <= watchdog_pkg::WINDOW_RESET;
            ctl_q.debug_stop <= watchdog_pkg::DEBUG_STOP_RESET;
            ctl_q.wait_halt <= watchdog_pkg::WAIT_HALT_RESET;
            ctl_q.stop_run <= watchdog_pkg::STOP_RUN_RESET;
            ctl_q.rate <= watchdog_pkg::RATE_RESET;
        end else begin
            if (field_write) begin
                if (special_mode || wr_ctl.window) begin
                    ctl_q.window <= wr_ctl.window;
                end
                if (special_mode || (wr_ctl.rate != watchdog_pkg::RATE_OFF)) begin
                    ctl_q.rate <= wr_ctl.rate;
                end
                ctl_q.wait_halt <= wr_ctl.wait_halt;
                ctl_q.stop_run <= wr_ctl.stop_run;
            end
            if (ctl_wr && (special_mode || wr_ctl.debug_stop)) begin
                ctl_q.debug_stop <= wr_ctl.debug_stop;
            end
        end
    end

    // A masked write leaves the allowance intact; any other write outside special modes uses it up.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fields_locked_q <= 1'b0;
        end else if (ctl_wr && !wdata[watchdog_pkg::WRITE_MASK_POS] && !special_mode) begin
            fields_locked_q <= 1'b1;
        end
    end

    assign enabled = (ctl_q.rate != watchdog_pkg::RATE_OFF);

    // During a debug session in special mode with debug-stop clear, the software
    // settings are overridden so the debugger never meets a short window.
    assign debug_override = enabled && debug_active_mode && !ctl_q.debug_stop
        && special_mode;
    assign eff_rate = debug_override ? watchdog_pkg::RATE_LONGEST : ctl_q.rate;
    assign eff_window = ctl_q.window && !debug_override;

    assign debug_halt = debug_active_mode && ctl_q.debug_stop;
    assign wait_halt_now = wait_mode && ctl_q.wait_halt;
    assign wait_entry = wait_mode && !wait_mode_q;
    assign stop_hold = stop_mode && !ctl_q.stop_run;

    assign run = enabled && !debug_halt && !wait_halt_now && !stop_hold;

    // Counter and registers share one clock here, so each request is a single
    // cycle pulse seen exactly once by the counter and never repeated.
    assign restart = rate_restart || debug_restart || svc_restart
        || (wait_entry && ctl_q.wait_halt);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wait_mode_q <= 1'b0;
        end else begin
            wait_mode_q <= wait_mode;
        end
    end

    watchdog_counter u_counter (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(run),
        .restart(restart),
        .rate(eff_rate),
        .expired(expired),
        .window_open(window_open)
    );

    // Service sequencer: first key arms, second key completes the service.
    always_comb begin
        svc_restart = 1'b0;
        svc_fault = 1'b0;
        if (key_wr && enabled) begin
            if (eff_window && !window_open) begin
                svc_fault = 1'b1;
            end else if (wdata == watchdog_pkg::KEY_FIRST) begin
                svc_fault = 1'b0;
            end else if (wdata == watchdog_pkg::KEY_SECOND) begin
                svc_restart = (svc_q == watchdog_pkg::SVC_ARMED);
                svc_fault = eff_window && (svc_q != watchdog_pkg::SVC_ARMED);
            end else begin
                svc_fault = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            svc_q <= watchdog_pkg::SVC_IDLE;
        end else begin
            case (svc_q)
                watchdog_pkg::SVC_IDLE: begin
                    if (svc_fault) begin
                        svc_q <= watchdog_pkg::SVC_FAULT;
                    end else if (key_wr && enabled && wdata == watchdog_pkg::KEY_FIRST) begin
                        svc_q <= watchdog_pkg::SVC_ARMED;
                    end
                end
                watchdog_pkg::SVC_ARMED: begin
                    if (svc_fault) begin
                        svc_q <= watchdog_pkg::SVC_FAULT;
                    end else if (svc_restart) begin
                        svc_q <= watchdog_pkg::SVC_IDLE;
                    end
                end
                watchdog_pkg::SVC_FAULT: begin
                    svc_q <= watchdog_pkg::SVC_FAULT;
                end
                default: begin
                    svc_q <= watchdog_pkg::SVC_IDLE;
                end
            endcase
        end
    end

    // The request is held until the system reset it causes clears the block.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reset_request_q <= 1'b0;
        end else if (expired || svc_fault) begin
            reset_request_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tick_halt_q <= 1'b0;
            running_q <= 1'b0;
        end else begin
            tick_halt_q <= debug_halt;
            running_q <= run;
        end
    end

    // Read port; the write mask and the service register always read zero.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (rd_en && addr == watchdog_pkg::CTL_OFFSET) begin
            rdata_q <= {ctl_q.window, ctl_q.debug_stop, 1'b0, ctl_q.wait_halt,
                        ctl_q.stop_run, ctl_q.rate};
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata = rdata_q;
    assign reset_request = reset_request_q;
    assign tick_halt = tick_halt_q;
    assign counter_running = running_q;

endmodule : window_watchdog_control
`default_nettype wire

// ### src/watchdog_pkg.sv
// Shared constants and types of the window watchdog.
// Assumes one system clock and a byte-wide register port.
package watchdog_pkg;

    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned CNT_W = 17;

    localparam logic [7:0] CTL_OFFSET = 8'h3e;
    localparam logic [7:0] KEY_OFFSET = 8'h3f;

    localparam int unsigned WINDOW_POS = 7;
    localparam int unsigned DEBUG_STOP_POS = 6;
    localparam int unsigned WRITE_MASK_POS = 5;
    localparam int unsigned WAIT_HALT_POS = 4;
    localparam int unsigned STOP_RUN_POS = 3;
    localparam int unsigned RATE_MSB = 2;

    localparam logic WINDOW_RESET = 1'h0;
    localparam logic DEBUG_STOP_RESET = 1'h0;
    localparam logic WAIT_HALT_RESET = 1'h0;
    localparam logic STOP_RUN_RESET = 1'h0;
    localparam logic [2:0] RATE_RESET = 3'h0;
    localparam logic [2:0] RATE_OFF = 3'h0;
    localparam logic [2:0] RATE_LONGEST = 3'h7;

    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    typedef struct packed {
        logic window;
        logic debug_stop;
        logic wait_halt;
        logic stop_run;
        logic [2:0] rate;
    } ctl_s;

    typedef enum logic [1:0] {
        SVC_IDLE,
        SVC_ARMED,
        SVC_FAULT
    } svc_state_e;

    // Timeout length in counter cycles for a rate code; zero when disabled.
    function automatic logic [CNT_W-1:0] rate_period(input logic [2:0] rate);
        logic [CNT_W:0] one;
        one = {{CNT_W{1'b0}}, 1'b1};
        case (rate)
            3'h1: rate_period = CNT_W'(one << 6);
            3'h2: rate_period = CNT_W'(one << 8);
            3'h3: rate_period = CNT_W'(one << 10);
            3'h4: rate_period = CNT_W'(one << 12);
            3'h5: rate_period = CNT_W'(one << 14);
            3'h6: rate_period = CNT_W'(one << 15);
            3'h7: rate_period = CNT_W'(one << 16);
            default: rate_period = '0;
        endcase
    endfunction : rate_period

    // First count of the closing quarter of the period.
    function automatic logic [CNT_W-1:0] window_start(input logic [2:0] rate);
        logic [CNT_W-1:0] p;
        p = rate_period(rate);
        window_start = p - (p >> 2);
    endfunction : window_start

endpackage : watchdog_pkg

// ### src/watchdog_counter.sv
// Timeout counter of the watchdog.
// Assumes the control logic supplies a rate that is non-zero while run is high.
`timescale 1ns/1ps
`default_nettype none
module watchdog_counter (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic run,
    input wire logic restart,
    input wire logic [2:0] rate,
    output logic expired,
    output logic window_open
);

    logic [watchdog_pkg::CNT_W-1:0] count_q;
    logic [watchdog_pkg::CNT_W-1:0] count_d;
    logic [watchdog_pkg::CNT_W-1:0] last_count;

    always_comb begin
        last_count = watchdog_pkg::rate_period(rate) - 17'h00001;
        expired = run && !restart && (count_q >= last_count);
        window_open = (count_q >= watchdog_pkg::window_start(rate));
        if (restart || expired) begin
            count_d = '0;
        end else if (run) begin
            count_d = count_q + 17'h00001;
        end else begin
            count_d = count_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

endmodule : watchdog_counter
`default_nettype wire

// ### verification/window_watchdog_control_checker.sv
// Port-level assertions for the window watchdog control block.
// Assumes it is bound to every window_watchdog_control instance.
`timescale 1ns/1ps
`default_nettype none
module window_watchdog_control_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic special_mode,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic debug_active_mode,
    input wire logic [7:0] rdata,
    input wire logic reset_request,
    input wire logic tick_halt,
    input wire logic counter_running
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    rdata_idle_a: assert property (!$past(rd_en) |-> rdata == 8'h00)
        else $error("read data outside read answer cycle");
    key_read_a: assert property ($past(rd_en) && $past(addr) == watchdog_pkg::KEY_OFFSET
        |-> rdata == 8'h00) else $error("service key read not zero");
    mask_read_a: assert property (rdata[5] == 1'b0) else $error("bit 5 read as one");
    reset_sticky_a: assert property (reset_request |=> reset_request)
        else $error("reset request dropped");
    bad_key_a: assert property (wr_en && addr == watchdog_pkg::KEY_OFFSET
        && counter_running && !special_mode && wdata != watchdog_pkg::KEY_FIRST
        && wdata != watchdog_pkg::KEY_SECOND |=> reset_request)
        else $error("bad key did not request reset");
    halt_stops_a: assert property (tick_halt |-> !counter_running)
        else $error("counter ran while debug halt");
    halt_cause_a: assert property (tick_halt |-> $past(debug_active_mode))
        else $error("tick halt without debug");
    reset_cause_a: assert property ($rose(reset_request)
        |-> counter_running || $past(wr_en)) else $error("reset request without cause");

    reset_seen_c: cover property ($rose(reset_request));
    halt_seen_c: cover property (tick_halt);
    ctl_read_c: cover property (rd_en && addr == watchdog_pkg::CTL_OFFSET);
endmodule : window_watchdog_control_checker

bind window_watchdog_control window_watchdog_control_checker window_watchdog_control_checker_i (
    .clk_sys, .rst, .addr, .wdata, .wr_en, .rd_en, .special_mode, .wait_mode, .stop_mode,
    .debug_active_mode, .rdata, .reset_request, .tick_halt, .counter_running);
`default_nettype wire

// ### verification/tb_window_watchdog_control.sv
// Self-checking bench for the window watchdog control block.
// Assumes the package constants and a one-cycle read answer.
`timescale 1ns/1ps
`default_nettype none
module tb_window_watchdog_control;
    localparam logic [7:0] CTL = watchdog_pkg::CTL_OFFSET;
    localparam logic [7:0] KEY = watchdog_pkg::KEY_OFFSET;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic special_mode = 1'b0;
    logic wait_mode = 1'b0;
    logic stop_mode = 1'b0;
    logic debug_active_mode = 1'b0;
    logic [7:0] rdata;
    logic reset_request;
    logic tick_halt;
    logic counter_running;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;

    window_watchdog_control window_watchdog_control_i (
        .clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .special_mode(special_mode), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .debug_active_mode(debug_active_mode), .rdata(rdata),
        .reset_request(reset_request), .tick_halt(tick_halt),
        .counter_running(counter_running));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    // The whole run needs well under this many cycles.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 99000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic idle(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : idle

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd

    task automatic restart_dut();
        @(posedge clk_sys);
        rst <= 1'b1;
        {special_mode, wait_mode, stop_mode, debug_active_mode} <= 4'h0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
    endtask : restart_dut

    // Counts cycles until the reset request shows, bounded.
    task automatic wait_rst(input int lim);
        n = 0;
        while (reset_request !== 1'b1 && n < lim) begin
            idle(1);
            n++;
        end
    endtask : wait_rst

    task automatic t_regs();
        restart_dut();
        rd(CTL, 8'h00);
        rd(8'h10, 8'h00);
        wr(KEY, 8'h12);
        idle(5);
        chk(reset_request, 1'b0);
        wr(CTL, 8'h00);
        wr(CTL, 8'h99);
        rd(CTL, 8'h00);
        chk(counter_running, 1'b0);
    endtask : t_regs

    task automatic t_once();
        restart_dut();
        wr(CTL, 8'h9a);
        rd(CTL, 8'h9a);
        wr(CTL, 8'h05);
        rd(CTL, 8'h9a);
        wr(CTL, 8'h60);
        rd(CTL, 8'hda);
        wr(CTL, 8'h00);
        rd(CTL, 8'hda);
        rd(KEY, 8'h00);
    endtask : t_once

    task automatic t_special();
        restart_dut();
        special_mode <= 1'b1;
        wr(CTL, 8'h41);
        wr(CTL, 8'h02);
        rd(CTL, 8'h02);
        @(posedge clk_sys);
        debug_active_mode <= 1'b1;
        idle(300);
        chk(reset_request, 1'b0);
        chk(counter_running, 1'b1);
    endtask : t_special

    task automatic t_rates();
        int p;
        for (int c = 1; c <= 6; c++) begin
            restart_dut();
            wr(CTL, 8'(c));
            p = (c < 6) ? (1 << (4 + 2 * c)) : (1 << 15);
            wait_rst(40000);
            chk(8'(n >= p - 3 && n <= p + 3), 8'h01);
        end
    endtask : t_rates

    task automatic t_service();
        restart_dut();
        wr(CTL, 8'h01);
        repeat (5) begin
            idle(30);
            wr(KEY, 8'h55);
            idle(3);
            wr(KEY, 8'haa);
        end
        wr(KEY, 8'h55);
        wr(KEY, 8'h55);
        idle(2);
        chk(reset_request, 1'b0);
        wr(KEY, 8'h3c);
        idle(1);
        chk(reset_request, 1'b1);
    endtask : t_service

    task automatic t_window();
        restart_dut();
        wr(CTL, 8'h81);
        idle(10);
        wr(KEY, 8'h55);
        idle(1);
        chk(reset_request, 1'b1);
        restart_dut();
        wr(CTL, 8'h81);
        idle(52);
        wr(KEY, 8'h55);
        wr(KEY, 8'h55);
        wr(KEY, 8'haa);
        idle(20);
        chk(reset_request, 1'b0);
        wr(KEY, 8'h55);
        idle(1);
        chk(reset_request, 1'b1);
    endtask : t_window

    task automatic t_low_power();
        restart_dut();
        wr(CTL, 8'h11);
        idle(30);
        @(posedge clk_sys);
        wait_mode <= 1'b1;
        idle(200);
        chk(reset_request | counter_running, 1'b0);
        @(posedge clk_sys);
        wait_mode <= 1'b0;
        wait_rst(100);
        chk(8'(n >= 60 && n <= 68), 8'h01);
        restart_dut();
        wr(CTL, 8'h01);
        idle(30);
        @(posedge clk_sys);
        stop_mode <= 1'b1;
        idle(200);
        chk(reset_request, 1'b0);
        @(posedge clk_sys);
        stop_mode <= 1'b0;
        wait_rst(100);
        chk(8'(n < 40), 8'h01);
    endtask : t_low_power

    task automatic t_debug();
        restart_dut();
        wr(CTL, 8'h01);
        idle(40);
        wr(CTL, 8'h60);
        debug_active_mode <= 1'b1;
        idle(200);
        chk(tick_halt, 1'b1);
        chk(reset_request, 1'b0);
        @(posedge clk_sys);
        debug_active_mode <= 1'b0;
        wait_rst(100);
        chk(8'(n >= 55 && n <= 68), 8'h01);
    endtask : t_debug

    task automatic wrap_up();
        if (failures == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_once();
        t_special();
        t_service();
        t_window();
        t_low_power();
        t_debug();
        t_rates();
        wrap_up();
    end
endmodule : tb_window_watchdog_control
`default_nettype wire
